/* File: design/smt_dev.sv */
// Purpose: special-mode select and timer A registers behind the serial link
// Assumes: link pins asynchronous to ref_clk, half clock period >= 8 cycles
// Notes: mode changes over the link need the secured read-then-write pair
// Function
// RULE1: top two data bits choose mode
// RULE2: secured access is read then write
// RULE3: read 0x1300 returns six-bit code
// RULE4: setup return writes 0x52, 01, inverted code
// RULE5: setup return only from normal mode
// RULE6: safe low only in setup, secured
// RULE7: safe write keeps bits 5:4, inverts 3:0
// RULE8: reset and reprog use same sequence
// RULE9: reprog mode allows watchdog lengthening
// RULE10: reset selection enters reset mode
// RULE11: mode and code fields clear on reset
// RULE12: timer A holds overcurrent and watchdog fields
// RULE13: overcurrent 3..24 or 4..32 ms
// RULE14: watchdog 2.5 ms doubling, scaled
// RULE15: parity bit checked or must be zero
// RULE16: mismatched secured write is ignored
module smt_dev
  import smt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  smt_link_if.dev link,
  input wire logic parity_en,
  input wire logic enter_normal,
  output smt_mode_type mode,
  output logic safe_low,
  output logic wd_extend_ok,
  output logic [7:0] special_mode_select,
  output logic [7:0] timer_a_overcurrent_watchdog,
  output logic [5:0] oc_time_ms,
  output logic [10:0] wd_period_half_ms,
  output logic frame_error
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] filt;
    logic [15:0] sh_in;
    logic [15:0] sh_out;
    logic [4:0] cnt;
    logic [5:0] lfsr;
    logic [5:0] code;
    logic armed;
    logic rnd_frame;
    logic [7:0] hold;
    smt_mode_type mode;
    logic [7:0] spe;
    logic [7:0] tima;
    logic safe_low;
    logic miso;
    logic [5:0] oc;
    logic [10:0] wd;
    logic ferr;
    logic ext;
  } smt_dev_type;

  smt_dev_type st;
  smt_dev_type next_st;

  function automatic logic [5:0] oc_of(input logic [7:0] r);
    return (r[7] ? OC_BASE_HI : OC_BASE_LO) << r[6:5];
  endfunction

  function automatic logic [10:0] wd_of(input logic [7:0] r);
    logic [10:0] b;
    b = WD_BASE0;
    case (r[4:3])
      2'h1: b = WD_BASE1;
      2'h2: b = WD_BASE2;
      2'h3: b = WD_BASE3;
      default: b = WD_BASE0;
    endcase
    return b << r[2:0];
  endfunction

  function automatic logic [7:0] read_data(input logic [15:0] w, input logic [5:0] c,
                                           input logic [7:0] spe, input logic [7:0] tima);
    logic [7:0] d;
    d = 8'h00;
    if (w[15:8] == RND_READ_CMD[15:8]) begin
      d = {2'h0, c}; // RULE3
    end else if (w[13:9] == ADDR_SPE) begin
      d = spe;
    end else if (w[13:9] == ADDR_TIMA) begin
      d = tima;
    end
    return d;
  endfunction

  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;
  logic [15:0] word;
  logic par_ok;
  logic [5:0] inv_code;
  logic [5:0] safe_code;

  always_comb begin
    next_st = st;
    rise = 1'b0;
    fall = 1'b0;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    word = st.sh_in;
    par_ok = 1'b0;
    inv_code = ~st.code;
    safe_code = st.code ^ {KEEP_MASK, FLIP_MASK}; // RULE7
    // Three-stage sync; a change counts once stages two and three agree
    next_st.s1 = {link.sclk, link.cs_n, link.mosi};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < 3; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.filt[i] = st.s3[i];
      end
    end
    rise = next_st.filt[2] & ~st.filt[2] & ~st.filt[1];
    fall = ~next_st.filt[2] & st.filt[2] & ~st.filt[1];
    cs_fall = ~next_st.filt[1] & st.filt[1];
    cs_rise = next_st.filt[1] & ~st.filt[1];
    next_st.lfsr = {st.lfsr[4:0], st.lfsr[5] ^ st.lfsr[4]};
    next_st.ferr = 1'b0;
    if (cs_fall) begin
      next_st.cnt = 5'h00;
      next_st.sh_out = 16'h0000;
      next_st.miso = 1'b0;
      next_st.rnd_frame = 1'b0;
    end
    if (rise && st.cnt != FRAME_BITS) begin
      next_st.sh_in = {st.sh_in[14:0], st.filt[0]};
      next_st.cnt = st.cnt + 5'h01;
      if (st.cnt == BYTE_BITS - 5'h01 && st.sh_in[6:5] == OP_READ) begin
        // Read answer goes out in the second byte of the same frame
        if ({st.sh_in[6:0], st.filt[0]} == RND_READ_CMD[15:8]) begin
          next_st.code = st.lfsr; // RULE3
          next_st.rnd_frame = 1'b1;
        end
        next_st.sh_out[14:7] = read_data({st.sh_in[6:0], st.filt[0], 8'h00},
                                         st.lfsr, st.spe, st.tima);
      end
    end
    if (fall) begin
      next_st.sh_out = {st.sh_out[14:0], 1'b0};
      next_st.miso = st.sh_out[14];
    end
    if (cs_rise) begin
      par_ok = parity_en ? (smt_par(word) == word[PAR_POS]) : ~word[PAR_POS]; // RULE15
      next_st.armed = 1'b0; // RULE2
      if (st.cnt != FRAME_BITS || (word[15:14] == OP_WRITE && !par_ok)) begin
        next_st.ferr = 1'b1;
      end else if (st.rnd_frame && word[7:0] == RND_READ_CMD[7:0]) begin
        next_st.armed = 1'b1; // RULE2
      end else if (word[15:14] == OP_WRITE && word[13:9] == ADDR_TIMA) begin
        next_st.tima = word[7:0]; // RULE12
      end else if (word[15:14] == OP_WRITE && word[13:9] == ADDR_SPE && st.armed) begin
        // Any other pattern leaves mode and safe output alone
        case (word[7:6]) // RULE1 RULE16
          SEL_SETUP: begin
            if (word[5:0] == inv_code && st.mode == SMT_NORMAL) begin
              next_st.mode = SMT_SETUP; // RULE4 RULE5
              next_st.spe = word[7:0];
            end else if (word[5:0] == safe_code && st.mode == SMT_SETUP) begin
              next_st.safe_low = 1'b1; // RULE6 RULE7
              next_st.spe = word[7:0];
            end
          end
          SEL_RESET: begin
            if (word[5:0] == inv_code) begin
              next_st.mode = SMT_RESET; // RULE8 RULE10
              next_st.hold = 8'h00;
              next_st.spe = word[7:0];
            end
          end
          SEL_REPROG: begin
            if (word[5:0] == inv_code) begin
              next_st.mode = SMT_REPROG; // RULE8
              next_st.spe = word[7:0];
            end
          end
          default: begin
            next_st.ferr = 1'b1;
          end
        endcase
      end
    end
    // Reset mode is held a fixed time, then falls back to setup
    case (st.mode)
      SMT_RESET: begin
        next_st.hold = st.hold + 8'h01;
        if (st.hold == HOLD_MAX) begin
          next_st.mode = SMT_SETUP; // RULE10
        end
      end
      SMT_SETUP: begin
        if (enter_normal) begin
          next_st.mode = SMT_NORMAL;
        end
      end
      SMT_NORMAL, SMT_REPROG: begin
      end
      default: begin
        next_st.mode = SMT_SETUP;
      end
    endcase
    next_st.oc = oc_of(next_st.tima); // RULE13
    next_st.wd = wd_of(next_st.tima); // RULE14
    next_st.ext = (next_st.mode == SMT_REPROG); // RULE9
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      // Idle levels, so no false edge follows reset
      st.s1 <= PIN_IDLE;
      st.s2 <= PIN_IDLE;
      st.s3 <= PIN_IDLE;
      st.filt <= PIN_IDLE;
      st.lfsr <= LFSR_SEED;
      st.spe <= SPE_RESET; // RULE11
      st.code <= 6'h00; // RULE11
      st.tima <= TIMA_RESET;
      st.mode <= SMT_SETUP;
      st.oc <= OC_BASE_LO;
      st.wd <= WD_BASE3 << 3'h6;
    end else begin
      st <= next_st;
    end
  end

  assign link.miso = st.miso;
  assign mode = st.mode;
  assign safe_low = st.safe_low;
  assign wd_extend_ok = st.ext; // RULE9
  assign special_mode_select = st.spe;
  assign timer_a_overcurrent_watchdog = st.tima;
  assign oc_time_ms = st.oc;
  assign wd_period_half_ms = st.wd;
  assign frame_error = st.ferr;
endmodule

/* File: design/smt_pkg.sv */
// Purpose: shared constants and types for the special-mode / timer A link
// Assumes: one 40 MHz clock on both ends, 16-bit framed serial link
// Notes: register offsets on the link are 5-bit addresses
package smt_pkg;
  localparam int CLK_NS = 25;
  localparam int RST_HOLD_NS = 1000;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_HALF_NS = 200;
  localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_NS;
  localparam logic [7:0] HOLD_MAX = 8'(RST_HOLD_CYC - 1);
  localparam logic [7:0] HALF_MAX = 8'(SCLK_HALF_CYC - 1);
  localparam logic [4:0] ADDR_SPE = 5'h09;
  localparam logic [4:0] ADDR_TIMA = 5'h0A;
  localparam logic [7:0] SPE_RESET = 8'h00;
  localparam logic [7:0] TIMA_RESET = 8'h1E;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [1:0] SEL_SETUP = 2'h1;
  localparam logic [1:0] SEL_REPROG = 2'h2;
  localparam logic [15:0] RND_READ_CMD = 16'h1300;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam int PAR_POS = 8;
  localparam logic [5:0] LFSR_SEED = 6'h2D;
  // Link pins at rest, ordered {sclk, cs_n, mosi}
  localparam logic [2:0] PIN_IDLE = 3'h2;
  localparam logic [1:0] KEEP_MASK = 2'h0;
  localparam logic [3:0] FLIP_MASK = 4'hF;
  localparam logic [5:0] OC_BASE_LO = 6'h03;
  localparam logic [5:0] OC_BASE_HI = 6'h04;
  localparam logic [10:0] WD_BASE0 = 11'h005;
  localparam logic [10:0] WD_BASE1 = 11'h006;
  localparam logic [10:0] WD_BASE2 = 11'h007;
  localparam logic [10:0] WD_BASE3 = 11'h008;
  // Controller register map, byte addresses
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_RESP = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_CFG = 4'hC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SMT_SETUP, SMT_NORMAL, SMT_RESET, SMT_REPROG
  } smt_mode_type;

  // Even parity over the whole word, bit 8 left out
  function automatic logic smt_par(input logic [15:0] w);
    return ^{w[15:PAR_POS+1], w[PAR_POS-1:0]};
  endfunction
endpackage

/* File: design/smt_link_if.sv */
// Purpose: four-wire serial link between controller and register device
// Assumes: controller drives clock and select, device drives miso
// Notes: clock idles low; data sampled on rising edge
interface smt_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport dev (input sclk, input cs_n, input mosi, output miso);
  modport ctl (output sclk, output cs_n, output mosi, input miso);
endinterface

/* File: design/smt_ctl.sv */
// Purpose: link controller taking 16-bit frames from AXI4-Lite registers
// Assumes: device samples on rising clock, answers on falling
// Notes: one frame at a time; command writes while busy are refused
module smt_ctl
  import smt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  smt_link_if.ctl link,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [1:0] {CTL_IDLE, CTL_LEAD, CTL_RUN, CTL_TAIL} ctl_state_type;
  typedef struct packed {
    ctl_state_type fsm;
    logic [7:0] div;
    logic [4:0] bits;
    logic [15:0] tx;
    logic [15:0] rx;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic par_en;
    logic done;
    logic aw_have;
    logic [3:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } smt_ctl_type;

  smt_ctl_type st;
  smt_ctl_type next_st;
  logic [15:0] frame;

  always_comb begin
    next_st = st;
    frame = st.w_data[15:0];
    // Write path: address and data in either order, answer after both
    next_st.awready = 1'b0;
    next_st.wready = 1'b0;
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_have = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_have = 1'b1;
      next_st.w_data = s_axi_wdata;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_have && st.w_have && !st.bvalid) begin
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      if (st.aw_addr == REG_CMD && st.fsm == CTL_IDLE) begin
        // Only writes carry parity; read commands keep bit 8 as given
        if (frame[15:14] == OP_WRITE) begin
          frame[PAR_POS] = st.par_en ? smt_par(frame) : 1'b0; // RULE15
        end
        next_st.tx = frame;
        next_st.fsm = CTL_LEAD;
        next_st.div = 8'h00;
        next_st.cs_n = 1'b0;
        next_st.mosi = frame[15];
        next_st.done = 1'b0;
      end else if (st.aw_addr == REG_CFG) begin
        next_st.par_en = st.w_data[0];
      end else begin
        next_st.bresp = RESP_SLVERR;
      end
    end else if (!st.bvalid) begin
      next_st.awready = !next_st.aw_have && !(s_axi_awvalid && st.awready);
      next_st.wready = !next_st.w_have && !(s_axi_wvalid && st.wready);
    end
    // Read path
    next_st.arready = !st.rvalid && !st.arready;
    if (s_axi_arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        REG_RESP: next_st.rdata = {16'h0000, st.rx};
        REG_STAT: next_st.rdata = {30'h0, st.done, st.fsm != CTL_IDLE};
        REG_CFG: next_st.rdata = {31'h0, st.par_en};
        REG_CMD: next_st.rdata = {16'h0000, st.tx};
        default: next_st.rdata = 32'h0000_0000;
      endcase
      next_st.rresp = (s_axi_araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    // Serial engine: half period per phase, MSB first
    if (st.fsm != CTL_IDLE) begin
      next_st.div = st.div + 8'h01;
    end
    case (st.fsm)
      CTL_IDLE: begin
      end
      CTL_LEAD: begin
        if (st.div == HALF_MAX) begin
          next_st.div = 8'h00;
          next_st.sclk = 1'b1;
          next_st.fsm = CTL_RUN;
        end
      end
      CTL_RUN: begin
        if (st.div == HALF_MAX) begin
          next_st.div = 8'h00;
          if (st.sclk) begin
            next_st.rx = {st.rx[14:0], link.miso};
            next_st.bits = st.bits + 5'h01;
            next_st.sclk = 1'b0;
            next_st.tx = {st.tx[14:0], 1'b0};
            next_st.mosi = st.tx[14];
            if (st.bits == FRAME_BITS - 5'h01) begin
              next_st.fsm = CTL_TAIL;
            end
          end else begin
            next_st.sclk = 1'b1;
          end
        end
      end
      CTL_TAIL: begin
        if (st.div == HALF_MAX) begin
          next_st.cs_n = 1'b1;
          next_st.bits = 5'h00;
          next_st.done = 1'b1;
          next_st.fsm = CTL_IDLE;
        end
      end
      default: begin
        next_st.fsm = CTL_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.cs_n <= 1'b1;
      st.fsm <= CTL_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign link.sclk = st.sclk;
  assign link.cs_n = st.cs_n;
  assign link.mosi = st.mosi;
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bresp = st.bresp;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_arready = st.arready;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rvalid = st.rvalid;
endmodule

/* File: verif/smt_link_checker.sv */
// Purpose: timing checks on the serial link between controller and device
// Assumes: one clock, half period of the link clock is 8 cycles
// Notes: sees only the link wires, clock and reset
module smt_link_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q;
  logic [4:0] rises;
  // Rising clock edges seen inside the current frame
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
      rises <= 5'h00;
    end else begin
      sclk_q <= sclk;
      if (cs_n) begin
        rises <= 5'h00;
      end else if (sclk && !sclk_q) begin
        rises <= rises + 5'h01;
      end
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence low_phase;
    !sclk [*7];
  endsequence
  sequence high_phase;
    sclk [*8];
  endsequence
  idle_clock_low_a: assert property (cs_n |-> !sclk)
    else $error("link clock moved outside a frame");
  high_phase_len_a: assert property ($rose(sclk) |-> high_phase ##1 !sclk)
    else $error("link clock high phase not 8 cycles");
  low_phase_len_a: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("link clock low phase too short");
  select_lead_a: assert property ($fell(cs_n) |-> low_phase ##[1:3] sclk)
    else $error("first clock edge not 8 cycles after select");
  mosi_steady_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi changed while clock high");
  miso_steady_a: assert property (sclk && $past(sclk) |-> $stable(miso))
    else $error("miso changed while clock high");
  frame_bits_a: assert property ($rose(cs_n) |-> rises == 5'h10)
    else $error("frame did not carry 16 clock edges");
  tail_gap_a: assert property ($fell(sclk) && rises == 5'h10 |-> low_phase ##[1:3] cs_n)
    else $error("select not released 8 cycles after last edge");
endmodule

/* File: verif/smt_test.sv */
// Purpose: drives the controller over AXI4-Lite and judges the device
// Assumes: parity and mode inputs of the device driven by the bench
// Notes: link timing judged by the checker
module smt_test
  import smt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic parity_en = 1'b0;
  logic enter_normal = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, safe_low, wd_ok, fe;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  smt_mode_type mode;
  logic [7:0] spe, tima;
  logic [5:0] oc;
  logic [10:0] wd;
  int n_mismatch = 0;
  int compares = 0;
  int fe_cnt = 0;
  smt_link_if link();
  smt_dev smt_dev_inst (.ref_clk(ref_clk), .rst(rst), .link(link), .parity_en(parity_en),
    .enter_normal(enter_normal), .mode(mode), .safe_low(safe_low), .wd_extend_ok(wd_ok),
    .special_mode_select(spe), .timer_a_overcurrent_watchdog(tima), .oc_time_ms(oc),
    .wd_period_half_ms(wd), .frame_error(fe));
  smt_ctl smt_ctl_inst (.ref_clk(ref_clk), .rst(rst), .link(link), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  smt_link_checker smt_link_checker_inst (.ref_clk(ref_clk), .rst(rst), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));
  always #12.5 ref_clk = ~ref_clk;
  // Error pulse lasts one cycle, so it is counted here
  always @(posedge ref_clk) if (fe === 1'b1) fe_cnt++;
  task automatic give_verdict();
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done)) begin
      @(posedge ref_clk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_done(output logic [15:0] resp);
    logic [31:0] d;
    logic [1:0] r;
    do rd(REG_STAT, d, r); while (d[1:0] !== 2'b10);
    rd(REG_RESP, d, r);
    resp = d[15:0];
    repeat (10) @(posedge ref_clk);
  endtask
  task automatic frame(input logic [15:0] f, output logic [15:0] resp);
    logic [1:0] r;
    wr(REG_CMD, {16'h0000, f}, r);
    chk("cmd bresp", 16'(RESP_OKAY), 16'(r));
    wait_done(resp);
  endtask
  task automatic code6(output logic [5:0] c);
    logic [15:0] s;
    frame(RND_READ_CMD, s);
    chk("code upper bits", 16'h0000, {s[15:6], 6'h00});
    c = s[5:0];
  endtask
  task automatic sec(input logic [1:0] sel, input logic [5:0] low);
    logic [15:0] s;
    frame({8'h52, sel, low}, s);
  endtask
  task automatic go_normal();
    @(posedge ref_clk);
    enter_normal <= 1'b1;
    @(posedge ref_clk);
    enter_normal <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("mode normal", 16'(SMT_NORMAL), 16'(mode));
  endtask
  task automatic t_reset();
    @(posedge ref_clk);
    chk("mode", 16'(SMT_SETUP), 16'(mode));
    chk("safe", 16'h0000, 16'(safe_low));
    chk("extend", 16'h0000, 16'(wd_ok));
    chk("spe", 16'h0000, 16'(spe));
    chk("tima", 16'h001E, 16'(tima));
    chk("oc", 16'h0003, 16'(oc));
    chk("wd", 16'h0200, 16'(wd));
  endtask
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] s;
    wr(4'h2, 32'h0, r);
    chk("unaligned bresp", 16'(RESP_SLVERR), 16'(r));
    wr(REG_RESP, 32'h0, r);
    chk("resp reg bresp", 16'(RESP_SLVERR), 16'(r));
    rd(4'h6, d, r);
    chk("unaligned rresp", 16'(RESP_SLVERR), 16'(r));
    wr(REG_CMD, 32'h1400, r);
    wr(REG_CMD, 32'h1400, r);
    chk("busy bresp", 16'(RESP_SLVERR), 16'(r));
    wait_done(s);
    chk("timer read", 16'h001E, s);
  endtask
  task automatic t_timer();
    logic [7:0] tv[3] = '{8'hE5, 8'h00, 8'h7B};
    logic [15:0] s;
    foreach (tv[i]) begin
      frame({8'h54, tv[i]}, s);
      chk("tima", 16'(tv[i]), 16'(tima));
      chk("oc", (tv[i][7] ? 16'h0004 : 16'h0003) << tv[i][6:5], 16'(oc));
      chk("wd", (16'h0005 + 16'(tv[i][4:3])) << tv[i][2:0], 16'(wd));
      frame(16'h1400, s);
      chk("timer read", 16'(tv[i]), s);
    end
  endtask
  task automatic t_secure();
    logic [5:0] c;
    logic [15:0] s;
    int n0;
    go_normal();
    code6(c);
    sec(SEL_SETUP, c);
    chk("bad code", 16'(SMT_NORMAL), 16'(mode));
    code6(c);
    sec(SEL_SETUP, {c[5:4], ~c[3:0]});
    chk("safe in normal", 16'h0000, 16'(safe_low));
    code6(c);
    sec(SEL_SETUP, ~c);
    chk("setup return", 16'(SMT_SETUP), 16'(mode));
    chk("spe setup", 16'({SEL_SETUP, ~c}), 16'(spe));
    code6(c);
    sec(SEL_SETUP, {c[5:4], ~c[3:0]});
    chk("safe in setup", 16'h0001, 16'(safe_low));
    go_normal();
    code6(c);
    frame(16'h1400, s);
    sec(SEL_REPROG, ~c);
    chk("disarmed", 16'(SMT_NORMAL), 16'(mode));
    code6(c);
    sec(SEL_REPROG, ~c);
    chk("reprog", 16'(SMT_REPROG), 16'(mode));
    chk("extend", 16'h0001, 16'(wd_ok));
    code6(c);
    sec(SEL_SETUP, ~c);
    chk("setup from reprog", 16'(SMT_REPROG), 16'(mode));
    n0 = fe_cnt;
    code6(c);
    sec(2'h3, ~c);
    chk("sel three error", 16'h0001, 16'(fe_cnt - n0));
    chk("sel three mode", 16'(SMT_REPROG), 16'(mode));
    code6(c);
    sec(SEL_RESET, ~c);
    chk("reset mode", 16'(SMT_RESET), 16'(mode));
    repeat (50) @(posedge ref_clk);
    chk("after reset", 16'(SMT_SETUP), 16'(mode));
  endtask
  task automatic t_parity();
    logic [1:0] r;
    logic [15:0] s;
    int n0;
    n0 = fe_cnt;
    wr(REG_CFG, 32'h1, r);
    chk("cfg bresp", 16'(RESP_OKAY), 16'(r));
    parity_en <= 1'b1;
    frame(16'h543C, s);
    chk("parity good", 16'h003C, 16'(tima));
    wr(REG_CFG, 32'h0, r);
    frame(16'h540F, s);
    chk("parity zeroed", 16'h003C, 16'(tima));
    wr(REG_CFG, 32'h1, r);
    parity_en <= 1'b0;
    frame(16'h540F, s);
    chk("parity not zero", 16'h003C, 16'(tima));
    chk("error pulses", 16'h0002, 16'(fe_cnt - n0));
  endtask
  // Whole run needs about 10000 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_bus();
    t_timer();
    t_secure();
    t_parity();
    give_verdict();
  end
endmodule
